// ---- rtl/lsrb_map.vh ----
`ifndef LSRB_MAP_VH
`define LSRB_MAP_VH
// Register offsets
`define LSRB_ADDR_ALIAS7 8'h48
`define LSRB_ADDR_BACK_CHANNEL_CONTROL 8'h49
`define LSRB_ADDR_REVISION 8'h50
`define LSRB_ADDR_INIT_STS 8'h51
`define LSRB_ADDR_GEN_STS 8'h52
`define LSRB_ADDR_PIN_LVL 8'h53
`define LSRB_ADDR_ST_CNT 8'h54
`define LSRB_ADDR_CK_CNT_LO 8'h55
`define LSRB_ADDR_CK_CNT_HI 8'h56
`define LSRB_ADDR_ALARM 8'h57
// Field positions
`define LSRB_BIT_AUTO_ACK 0
`define LSRB_BIT_ST_CLR 5
`define LSRB_BIT_RSVD_RW 4
`define LSRB_BIT_CK_CLR 3
`define LSRB_BIT_CFG_VALID 7
`define LSRB_BIT_INIT_DONE 6
`define LSRB_BIT_RX_LOCK 6
`define LSRB_BIT_LINK_LOST 4
`define LSRB_BIT_ST_FAIL 3
`define LSRB_BIT_PLL_LOCK 2
`define LSRB_BIT_CK_FAIL 1
`define LSRB_BIT_BC_VALID 0
`define LSRB_BIT_OVER_TEMP 5
// Reset values and counter saturation limits
`define LSRB_RST_ALIAS7 8'h00
`define LSRB_RST_BACK_CHANNEL_CONTROL 8'h00
`define LSRB_RST_CNT8 8'h00
`define LSRB_RST_CNT16 16'h0000
`define LSRB_CNT8_MAX 8'hFF
`define LSRB_CNT16_MAX 16'hFFFF
// Synced PLL lock and link valid start high
`define LSRB_RST_ST_SYNC 6'h18
// Identity, arbitrary values
`define LSRB_SILICON_REV 4'h5
`define LSRB_MASK_SET 4'hA
`endif

// ---- rtl/lsrb_link_status_bank.v ----
// Implementation choice: strobed register access.
`include "lsrb_map.vh"

module lsrb_link_status_bank (
    input wire clk_sys_i,
    input wire rst_i,
    input wire clk_en_i,
    input wire [7:0] reg_addr_i,
    input wire [7:0] reg_wdata_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    output reg [7:0] reg_rdata_o,
    input wire [6:0] i2c_addr_i,
    input wire i2c_addr_valid_i,
    output wire remote_hit_o,
    output wire remote_auto_ack_o,
    output wire [2:0] link_detect_interval_o,
    input wire init_done_i,
    input wire fuse_config_valid_i,
    input wire remote_lock_i,
    input wire back_channel_valid_i,
    input wire forward_pll_locked_i,
    input wire check_fail_i,
    input wire selftest_fail_i,
    input wire [3:0] pin_levels_i,
    input wire over_temperature_i
);

    // Init capture states, one-hot
    localparam [1:0] INIT_WAIT = 2'b01;
    localparam [1:0] INIT_HELD = 2'b10;

    // Two-flop synchronisers for asynchronous status inputs
    wire [5:0] st_raw;
    reg [3:0] pin_meta;
    reg [3:0] pin_sync;
    reg [5:0] st_meta;
    reg [5:0] st_sync;

    // Control storage
    reg [6:0] remote_alias_address;
    reg auto_ack;
    reg rsvd_rw;
    reg [2:0] link_detect_interval;
    reg selftest_counter_clear;
    reg check_fail_clear;

    // Init capture state
    reg [1:0] init_state;
    reg [1:0] next_init_state;

    // Status storage and next values
    reg init_done;
    reg fuse_config_valid;
    reg next_fuse_config_valid;
    reg link_lost_flag;
    reg next_link_lost_flag;
    reg check_fail_flag;
    reg next_check_fail_flag;
    reg selftest_fail_flag;
    reg next_selftest_fail_flag;
    reg over_temperature_alarm;
    reg next_over_temperature_alarm;
    reg bc_valid_q;

    // Error tallies and next values
    reg [7:0] selftest_fail_tally;
    reg [7:0] next_selftest_fail_tally;
    reg [15:0] check_fail_tally;
    reg [15:0] next_check_fail_tally;

    // Read path
    reg [7:0] next_rdata;
    wire [7:0] alias_image;
    wire [7:0] back_channel_control_image;
    wire [7:0] revision_image;
    wire [7:0] init_image;
    wire [7:0] gen_status_image;
    wire [7:0] pin_image;
    wire [7:0] alarm_image;

    // Synced status levels, named by meaning
    wire s_init = st_sync[0];
    wire s_cfg = st_sync[1];
    wire s_lock = st_sync[2];
    wire s_bcv = st_sync[3];
    wire s_pll = st_sync[4];
    wire s_temp = st_sync[5];

    // Bus decode for registers with side effects
    wire wr_alias = reg_wr_i && (reg_addr_i == `LSRB_ADDR_ALIAS7);
    wire wr_bc = reg_wr_i && (reg_addr_i == `LSRB_ADDR_BACK_CHANNEL_CONTROL);
    wire rd_bc = reg_rd_i && (reg_addr_i == `LSRB_ADDR_BACK_CHANNEL_CONTROL);
    wire rd_alarm = reg_rd_i && (reg_addr_i == `LSRB_ADDR_ALARM);

    // Status events
    wire link_changed = (s_bcv != bc_valid_q);
    wire check_event = check_fail_i && s_bcv;
    wire st_cnt_full = (selftest_fail_tally == `LSRB_CNT8_MAX);
    wire ck_cnt_full = (check_fail_tally == `LSRB_CNT16_MAX);

    // Remote decode; zero alias means never forward
    assign remote_hit_o = i2c_addr_valid_i && (remote_alias_address != 7'h00) &&
                          (i2c_addr_i == remote_alias_address);
    assign remote_auto_ack_o = remote_hit_o && auto_ack;
    assign link_detect_interval_o = link_detect_interval;

    // Raw status levels gathered for one synchroniser bank
    assign st_raw = {over_temperature_i, forward_pll_locked_i, back_channel_valid_i,
                     remote_lock_i, fuse_config_valid_i, init_done_i};

    // Pin synchroniser: first stage is read only by the second
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            pin_meta <= 4'h0;
            pin_sync <= 4'h0;
        end else if (clk_en_i) begin
            pin_meta <= pin_levels_i;
            pin_sync <= pin_meta;
        end
    end

    // Status synchroniser; PLL lock and link start high to avoid a false edge
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            st_meta <= `LSRB_RST_ST_SYNC;
            st_sync <= `LSRB_RST_ST_SYNC;
        end else if (clk_en_i) begin
            st_meta <= st_raw;
            st_sync <= st_meta;
        end
    end

    // Alias register
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            remote_alias_address <= 7'h00;
            auto_ack <= 1'b0;
        end else if (clk_en_i) begin
            if (wr_alias) begin
                remote_alias_address <= reg_wdata_i[7:1];
                auto_ack <= reg_wdata_i[`LSRB_BIT_AUTO_ACK];
            end
        end
    end

    // Back-channel control storage bits
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            rsvd_rw <= 1'b0;
            link_detect_interval <= 3'h0;
        end else if (clk_en_i) begin
            if (wr_bc) begin
                rsvd_rw <= reg_wdata_i[`LSRB_BIT_RSVD_RW];
                link_detect_interval <= reg_wdata_i[2:0];
            end
        end
    end

    // Clear bits pulse one cycle and never read back as 1
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            selftest_counter_clear <= 1'b0;
            check_fail_clear <= 1'b0;
        end else if (clk_en_i) begin
            selftest_counter_clear <= wr_bc && reg_wdata_i[`LSRB_BIT_ST_CLR];
            check_fail_clear <= wr_bc && reg_wdata_i[`LSRB_BIT_CK_CLR];
        end
    end

    // Init capture: wait for synced done, then hold until reset
    always @* begin
        next_init_state = init_state;
        case (init_state)
            INIT_WAIT: begin
                if (s_init)
                    next_init_state = INIT_HELD;
            end
            INIT_HELD: begin
                next_init_state = INIT_HELD;
            end
            default: begin
                next_init_state = INIT_WAIT;
            end
        endcase
    end

    // Checksum is sampled once, on the leaving edge of the wait state
    always @* begin
        next_fuse_config_valid = fuse_config_valid;
        if (init_state == INIT_WAIT && s_init)
            next_fuse_config_valid = s_cfg;
    end

    // Init status flops
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            init_state <= INIT_WAIT;
            init_done <= 1'b0;
            fuse_config_valid <= 1'b0;
        end else if (clk_en_i) begin
            init_state <= next_init_state;
            init_done <= next_init_state[1];
            fuse_config_valid <= next_fuse_config_valid;
        end
    end

    // Link-lost flag; a new change wins over a same-cycle clear
    always @* begin
        next_link_lost_flag = link_lost_flag;
        if (link_changed)
            next_link_lost_flag = 1'b1;
        else if (rd_bc || !s_pll)
            next_link_lost_flag = 1'b0;
    end

    // Check-fail flag; cleared by reading or by the write-1 clear
    always @* begin
        next_check_fail_flag = check_fail_flag;
        if (check_event)
            next_check_fail_flag = 1'b1;
        else if (rd_bc || check_fail_clear)
            next_check_fail_flag = 1'b0;
    end

    // Self-test flag follows the counter clear
    always @* begin
        next_selftest_fail_flag = selftest_fail_flag;
        if (selftest_fail_i)
            next_selftest_fail_flag = 1'b1;
        else if (selftest_counter_clear)
            next_selftest_fail_flag = 1'b0;
    end

    // Alarm set while hot; a read during the alarm does not lose it
    always @* begin
        next_over_temperature_alarm = over_temperature_alarm;
        if (s_temp)
            next_over_temperature_alarm = 1'b1;
        else if (rd_alarm)
            next_over_temperature_alarm = 1'b0;
    end

    // Sticky flag flops
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            bc_valid_q <= 1'b1;
            link_lost_flag <= 1'b0;
            check_fail_flag <= 1'b0;
            selftest_fail_flag <= 1'b0;
            over_temperature_alarm <= 1'b0;
        end else if (clk_en_i) begin
            bc_valid_q <= s_bcv;
            link_lost_flag <= next_link_lost_flag;
            check_fail_flag <= next_check_fail_flag;
            selftest_fail_flag <= next_selftest_fail_flag;
            over_temperature_alarm <= next_over_temperature_alarm;
        end
    end

    // Self-test tally; clear beats a same-cycle count
    always @* begin
        next_selftest_fail_tally = selftest_fail_tally;
        if (selftest_counter_clear)
            next_selftest_fail_tally = `LSRB_RST_CNT8;
        else if (selftest_fail_i && !st_cnt_full)
            next_selftest_fail_tally = selftest_fail_tally + 8'h01;
    end

    // Check tally saturates so a big count never looks small
    always @* begin
        next_check_fail_tally = check_fail_tally;
        if (check_event && !ck_cnt_full)
            next_check_fail_tally = check_fail_tally + 16'h0001;
    end

    // Tally flops
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            selftest_fail_tally <= `LSRB_RST_CNT8;
            check_fail_tally <= `LSRB_RST_CNT16;
        end else if (clk_en_i) begin
            selftest_fail_tally <= next_selftest_fail_tally;
            check_fail_tally <= next_check_fail_tally;
        end
    end

    // Register images; reserved bits tied low, except rsvd_rw at bit 4 of back-channel control, which reads back as written
    assign alias_image = {remote_alias_address, auto_ack};
    assign back_channel_control_image = {3'h0, rsvd_rw, 1'b0, link_detect_interval};
    assign revision_image = {`LSRB_SILICON_REV, `LSRB_MASK_SET};
    assign init_image = {fuse_config_valid, init_done, 6'h00};
    assign gen_status_image = {1'b0, s_lock, 1'b0, link_lost_flag,
                               selftest_fail_flag, s_pll, check_fail_flag, s_bcv};
    assign pin_image = {4'h0, pin_sync};
    assign alarm_image = {2'h0, over_temperature_alarm, 5'h00};

    // Read select; unmapped addresses return zero
    always @* begin
        next_rdata = 8'h00;
        if (reg_rd_i) begin
            case (reg_addr_i)
                `LSRB_ADDR_ALIAS7: next_rdata = alias_image;
                `LSRB_ADDR_BACK_CHANNEL_CONTROL: next_rdata = back_channel_control_image;
                `LSRB_ADDR_REVISION: next_rdata = revision_image;
                `LSRB_ADDR_INIT_STS: next_rdata = init_image;
                `LSRB_ADDR_GEN_STS: next_rdata = gen_status_image;
                `LSRB_ADDR_PIN_LVL: next_rdata = pin_image;
                `LSRB_ADDR_ST_CNT: next_rdata = selftest_fail_tally;
                `LSRB_ADDR_CK_CNT_LO: next_rdata = check_fail_tally[7:0];
                `LSRB_ADDR_CK_CNT_HI: next_rdata = check_fail_tally[15:8];
                `LSRB_ADDR_ALARM: next_rdata = alarm_image;
                default: next_rdata = 8'h00;
            endcase
        end
    end

    // Read data flop: stands one cycle, then returns to zero
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            reg_rdata_o <= 8'h00;
        end else if (clk_en_i) begin
            reg_rdata_o <= next_rdata;
        end
    end

endmodule

// ---- tb/lsrb_remote_model.sv ----
// Far-side deserializer: lock and link levels plus bursts of back-channel errors
module lsrb_remote_model (
    input wire logic clk_sys_i,
    input wire logic [7:0] n_i,
    input wire logic go_i,
    input wire logic lock_i,
    input wire logic link_i,
    output logic remote_lock_o,
    output logic link_o,
    output logic check_fail_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] left = 8'h00;
    assign remote_lock_o = lock_i;
    assign link_o = link_i;
    // One error pulse a cycle, so bursts test back-to-back counting
    always @(posedge clk_sys_i) begin
        if (go_i) left <= n_i;
        else if (left != 8'h00) left <= left - 8'h01;
    end
    assign check_fail_o = left != 8'h00;
endmodule

// ---- tb/lsrb_checker_asserts.sv ----
module lsrb_checker (
    input wire clk_sys_i,
    input wire rst_i,
    input wire clk_en_i,
    input wire [7:0] reg_addr_i,
    input wire [7:0] reg_wdata_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    input wire [7:0] reg_rdata_o,
    input wire [6:0] i2c_addr_i,
    input wire i2c_addr_valid_i,
    input wire remote_hit_o,
    input wire remote_auto_ack_o,
    input wire [2:0] link_detect_interval_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    logic [7:0] al;
    wire tk = clk_en_i && reg_rd_i;
    wire [2:0] wd = reg_wdata_i[2:0];
    wire mp = reg_addr_i inside {[8'h48:8'h49], [8'h50:8'h57]};
    // Shadow of the alias register, tracked from the bus alone
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) al <= 8'h00;
        else if (clk_en_i && reg_wr_i && reg_addr_i == 8'h48) al <= reg_wdata_i;
    end
    hit_decode_a: assert property (remote_hit_o == (i2c_addr_valid_i && al[7:1] != 7'h00 && i2c_addr_i == al[7:1]))
        else $error("alias decode wrong");
    zero_alias_a: assert property (al[7:1] == 7'h00 |-> !remote_hit_o)
        else $error("hit with zero alias");
    auto_ack_a: assert property (remote_auto_ack_o == (remote_hit_o && al[0]))
        else $error("auto ack wrong");
    alias_rd_a: assert property (tk && reg_addr_i == 8'h48 |=> reg_rdata_o == $past(al))
        else $error("alias readback wrong");
    interval_wr_a: assert property (clk_en_i && reg_wr_i && reg_addr_i == 8'h49 |=> link_detect_interval_o == $past(wd))
        else $error("interval not written");
    back_channel_control_rd_a: assert property (tk && reg_addr_i == 8'h49 |=> reg_rdata_o[2:0] == $past(link_detect_interval_o)
        && reg_rdata_o[7:5] == 3'h0 && !reg_rdata_o[3])
        else $error("control readback wrong");
    pin_upper_a: assert property (tk && reg_addr_i == 8'h53 |=> reg_rdata_o[7:4] == 4'h0)
        else $error("pin upper bits set");
    unmapped_rd_a: assert property (tk && !mp |=> reg_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    cover property (remote_auto_ack_o);
    cover property (reg_wr_i && reg_addr_i == 8'h49 && reg_wdata_i[5]);
    cover property (tk && reg_addr_i == 8'h52);
endmodule
bind lsrb_link_status_bank lsrb_checker i_chk (.*);

// ---- tb/lsrb_link_status_bank_tb.sv ----
module lsrb_link_status_bank_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys_i = 0, rst_i = 1, clk_en_i = 1, reg_wr_i = 0, reg_rd_i = 0, i2c_addr_valid_i = 0, init_done_i = 0;
    logic fuse_config_valid_i = 1, forward_pll_locked_i = 1, selftest_fail_i = 0, over_temperature_i = 0;
    logic go = 0, lk = 1, ln = 1, remote_lock_i, back_channel_valid_i, check_fail_i, remote_hit_o, remote_auto_ack_o;
    logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o, n = 8'h00;
    logic [6:0] i2c_addr_i = 7'h00;
    logic [3:0] pin_levels_i = 4'h0;
    logic [2:0] link_detect_interval_o;
    int num_errors = 0, checks_done = 0;
    initial forever #10 clk_sys_i = ~clk_sys_i;
    lsrb_link_status_bank i_dut (.*);
    lsrb_remote_model i_rem (.clk_sys_i(clk_sys_i), .n_i(n), .go_i(go), .lock_i(lk), .link_i(ln),
        .remote_lock_o(remote_lock_i), .link_o(back_channel_valid_i), .check_fail_o(check_fail_i));
    task chk(string s, logic [7:0] g, logic [7:0] e);
        checks_done++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %s exp %h got %h", s, e, g);
        end
    endtask
    task cy(int k); repeat (k) @(posedge clk_sys_i); endtask
    task wr(logic [7:0] a, logic [7:0] v);
        @(posedge clk_sys_i); reg_wr_i <= 1; reg_addr_i <= a; reg_wdata_i <= v;
        @(posedge clk_sys_i); reg_wr_i <= 0;
    endtask
    // Read data stand only in the cycle after the strobe
    task rd(logic [7:0] a, logic [7:0] e, string s);
        @(posedge clk_sys_i); reg_rd_i <= 1; reg_addr_i <= a;
        @(posedge clk_sys_i); reg_rd_i <= 0;
        @(negedge clk_sys_i) chk(s, reg_rdata_o, e);
        @(posedge clk_sys_i);
    endtask
    task st(int k); @(posedge clk_sys_i); selftest_fail_i <= 1; cy(k); selftest_fail_i <= 0; endtask
    task t_rst;
        rd(8'h52, 8'h05, "status");
        rd(8'h51, 8'h00, "init");
        rd(8'h55, 8'h00, "crc lo");
    endtask
    task t_init; init_done_i <= 1; cy(4); rd(8'h51, 8'hC0, "init"); endtask
    task t_lock; rd(8'h52, 8'h45, "lock"); endtask
    task t_alias;
        wr(8'h48, 8'h55); i2c_addr_i <= 7'h2A; i2c_addr_valid_i <= 1; cy(2);
        @(negedge clk_sys_i) chk("hit", remote_hit_o, 1);
        chk("ack", remote_auto_ack_o, 1);
        wr(8'h48, 8'h01); i2c_addr_i <= 7'h00; cy(2);
        @(negedge clk_sys_i) chk("hit0", remote_hit_o, 0);
    endtask
    task t_crc;
        @(posedge clk_sys_i); n <= 8'h03; go <= 1; @(posedge clk_sys_i); go <= 0; cy(6);
        rd(8'h55, 8'h03, "crc lo");
        rd(8'h52, 8'h47, "crc flag");
        rd(8'h49, 8'h00, "ctrl");
        rd(8'h52, 8'h45, "flag clr");
        ln <= 0; cy(4); rd(8'h52, 8'h54, "link lost");
        ln <= 1; cy(4); forward_pll_locked_i <= 0; cy(4);
        rd(8'h52, 8'h41, "pll loss");
        forward_pll_locked_i <= 1; cy(4);
    endtask
    task t_st;
        st(2); cy(2); rd(8'h54, 8'h02, "st cnt");
        rd(8'h52, 8'h4D, "st flag");
        wr(8'h49, 8'h27); rd(8'h54, 8'h00, "st clr");
        rd(8'h49, 8'h07, "ctrl");
        st(300); cy(2); wr(8'h54, 8'h11); rd(8'h54, 8'hFF, "st sat");
    endtask
    task t_misc;
        pin_levels_i <= 4'hA; over_temperature_i <= 1; cy(4); over_temperature_i <= 0; cy(4);
        rd(8'h53, 8'h0A, "pins");
        rd(8'h57, 8'h20, "temp");
        rd(8'h57, 8'h00, "temp clr");
        rd(8'h60, 8'h00, "unmapped");
    endtask
    // Write-1 clear of the check flag, then a write frozen by the enable
    task t_cen;
        @(posedge clk_sys_i); n <= 8'h01; go <= 1; @(posedge clk_sys_i); go <= 0; cy(4);
        rd(8'h52, 8'h4F, "crc set");
        wr(8'h49, 8'h0F); rd(8'h52, 8'h4D, "crc wclr");
        @(posedge clk_sys_i); clk_en_i <= 0; reg_wr_i <= 1; reg_addr_i <= 8'h49; reg_wdata_i <= 8'h00;
        @(posedge clk_sys_i); reg_wr_i <= 0; clk_en_i <= 1;
        rd(8'h49, 8'h07, "frozen");
    endtask
    task report_and_stop;
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        cy(5); rst_i <= 0;
        t_rst; t_init; t_lock; t_alias; t_crc; t_st; t_misc; t_cen;
        report_and_stop;
    end
    // Hang guard
    initial begin cy(3000); num_errors++; report_and_stop; end
endmodule
